//--- core/discard_state_pointer_select.sv
// The implementer's own choice: the APB register port.
`timescale 1ns/10ps
`include "dsp_params.svh"
module discard_state_pointer_select
    import dsp_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic cell_valid,
    input wire logic [31:0] std_hdr,
    input wire logic [15:0] tandem_hdr,
    input wire logic [15:0] bus_hdr,
    output logic [12:0] ptr,
    output logic ptr_valid
);

    // Selector fields, one per offset bit
    sel_t src_q [`PTR_W];
    // Selector view padded with a zero slot for the odd pair
    sel_t sel_w [`PTR_W + 1];
    // Read data captured in the setup phase
    word_t prdata_q;
    // Error answer captured in the setup phase
    logic pslverr_q;
    // Assembled pointer and its strobe
    ptr_t ptr_q;
    logic ptr_valid_q;

    // Word index and alignment of the access
    logic [9:0] idx;
    logic aligned;
    // Phases of the transfer
    logic setup;
    logic access;
    logic wr_en;
    // Per pair address hit
    logic [`NUM_PAIRS-1:0] hit;
    // Status register hit and overall map hit
    logic hit_status;
    logic mapped;
    // Read data accumulated across pairs
    word_t rd_chain [`NUM_PAIRS + 1];
    word_t rd_data;
    // All header bits in selector order
    logic [63:0] hdr_all;
    // Selected bit per offset position
    ptr_t ptr_d;

    // Named views of the documented fields
    sel_t offset_bit4_source;
    sel_t offset_bit5_source;
    sel_t offset_msb_source;
    sel_t offset_lsb_source;

    assign offset_bit4_source = src_q[`PTR_BIT4];
    assign offset_bit5_source = src_q[`PTR_BIT5];
    assign offset_msb_source = src_q[`PTR_W - 1];
    assign offset_lsb_source = src_q[0];

    // Bus decode
    assign idx = paddr[11:2];
    assign aligned = (paddr[1:0] == 2'h0);
    assign setup = psel & ~penable;
    assign access = psel & penable;
    // Single wait-free access phase, so pready is simply the phase
    assign pready = access;
    assign wr_en = access & pwrite & mapped;
    assign hit_status = aligned & (idx == `IDX_STATUS);
    assign mapped = (|hit) | hit_status;

    // Zero slot makes the lone msb field read like a pair
    assign sel_w[`PTR_W] = '0;

    // Header concatenation: standard low, tandem middle, bus high
    assign hdr_all = {bus_hdr, tandem_hdr, std_hdr};

    // Selector fields, their decode, write and read paths
    generate
        for (genvar i = 0; i < `PTR_W; i++) begin : g_field
            // Pair that holds this field, and where in the word
            localparam logic [9:0] FIDX = 10'(`IDX_PAIR0 - `IDX_STEP * (i / 2));
            localparam int LO = `FIELD1_LO * (i % 2);
            logic fhit;
            assign fhit = aligned & (idx == FIDX);
            assign sel_w[i] = src_q[i];

            // Field register; unknown reset replaced by the force-zero code
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    src_q[i] <= `SEL_RST;
                end else if (wr_en && fhit) begin
                    // Write takes effect at the access edge only
                    src_q[i] <= pwdata[LO +: `SEL_W];
                end
            end

            // Offset bit: forced zero beats the header mapping
            assign ptr_d[i] = (src_q[i] == `SEL_FORCE0) ? 1'b0
                : hdr_all[src_q[i]];
        end

        for (genvar k = 0; k < `NUM_PAIRS; k++) begin : g_pair
            localparam logic [9:0] PIDX = 10'(`IDX_PAIR0 - `IDX_STEP * k);
            word_t word;
            assign hit[k] = aligned & (idx == PIDX);
            // Upper bits of every pair word read zero
            assign word = {20'h0, sel_w[2*k+1], sel_w[2*k]};
            assign rd_chain[k+1] = rd_chain[k] | (hit[k] ? word : '0);
        end
    endgenerate

    // Read mux: pairs, then the pointer status word
    assign rd_chain[0] = hit_status ? {19'h0, ptr_q} : '0;
    assign rd_data = rd_chain[`NUM_PAIRS];

    // Answer prepared at setup so prdata comes from a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            // Unmapped or unaligned words answer with an error
            prdata_q <= pwrite ? '0 : rd_data;
            pslverr_q <= ~mapped;
        end
    end

    assign prdata = prdata_q;
    assign pslverr = pslverr_q & access;

    // Pointer register: holds the last cell's offset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ptr_q <= '0;
            ptr_valid_q <= 1'b0;
        end else begin
            // One pointer per received cell
            ptr_valid_q <= cell_valid;
            if (cell_valid) begin
                ptr_q <= ptr_d;
            end
        end
    end

    assign ptr = ptr_q;
    assign ptr_valid = ptr_valid_q;

    // Checks below watch design-driven outputs and the selector fields
    // Bit 4 from standard header when selector below 32
    property p_bit4_std;
        @(posedge pclk) disable iff (!presetn)
        (cell_valid && offset_bit4_source <= `SEL_STD_LAST)
        |=> ptr[4] == $past(std_hdr[offset_bit4_source[4:0]]);
    endproperty
    a_bit4_std: assert property (p_bit4_std)
        else $error("offset bit 4 not taken from standard header");

    // Bit 5 from tandem header for 32..47
    property p_bit5_tdm;
        @(posedge pclk) disable iff (!presetn)
        (cell_valid && offset_bit5_source >= `SEL_TDM_FIRST
            && offset_bit5_source <= `SEL_TDM_LAST)
        |=> ptr[5] == $past(tandem_hdr[offset_bit5_source[3:0]]);
    endproperty
    a_bit5_tdm: assert property (p_bit5_tdm)
        else $error("offset bit 5 not taken from tandem header");

    // Msb from bus routing header above 48
    property p_msb_bus;
        @(posedge pclk) disable iff (!presetn)
        (cell_valid && offset_msb_source > `SEL_BUS_FIRST)
        |=> ptr[12] == $past(bus_hdr[offset_msb_source[3:0]]);
    endproperty
    a_msb_bus: assert property (p_msb_bus)
        else $error("offset msb not taken from bus routing header");

    // Lsb from the standard header, tied to selector zero
    property p_lsb_std;
        @(posedge pclk) disable iff (!presetn)
        (cell_valid && offset_lsb_source <= `SEL_STD_LAST)
        |=> ptr[0] == $past(std_hdr[offset_lsb_source[4:0]]);
    endproperty
    a_lsb_std: assert property (p_lsb_std)
        else $error("offset lsb not taken from selector zero");

    // Force-zero pattern gives zero whatever the headers hold
    property p_force0;
        @(posedge pclk) disable iff (!presetn)
        (cell_valid && offset_bit4_source == `SEL_FORCE0) |=> !ptr[4];
    endproperty
    a_force0: assert property (p_force0)
        else $error("forced offset bit not zero");

    // One strobe per cell, pointer stable between cells
    property p_one_ptr;
        @(posedge pclk) disable iff (!presetn)
        !cell_valid |=> !ptr_valid && $stable(ptr);
    endproperty
    a_one_ptr: assert property (p_one_ptr)
        else $error("pointer moved without a cell");

    // Write to the documented word lands in both fields
    property p_write45;
        @(posedge pclk) disable iff (!presetn)
        (access && pwrite && aligned && idx == `IDX_BITS45)
        |=> offset_bit4_source == $past(pwdata[5:0])
            && offset_bit5_source == $past(pwdata[11:6]);
    endproperty
    a_write45: assert property (p_write45)
        else $error("selector write for bits 4 and 5 lost");

    // Read of the documented word: fields back, upper bits zero
    property p_read45;
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && aligned && idx == `IDX_BITS45)
        ##1 access
        |-> prdata[31:12] == 20'h0
            && prdata[11:0] == {offset_bit5_source, offset_bit4_source};
    endproperty
    a_read45: assert property (p_read45)
        else $error("readback of bits 4 and 5 wrong");

    // Unmapped word answers with an error in the access phase
    property p_unmapped;
        @(posedge pclk) disable iff (!presetn)
        (setup && !mapped) ##1 access |-> pslverr && pready;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped access not flagged");

    // Bit 4 from bus routing header above the force code
    property p_bit4_bus;
        @(posedge pclk) disable iff (!presetn)
        (cell_valid && offset_bit4_source > `SEL_BUS_FIRST)
        |=> ptr[`PTR_BIT4] == $past(bus_hdr[offset_bit4_source[3:0]]);
    endproperty
    a_bit4_bus: assert property (p_bit4_bus)
        else $error("offset bit 4 not taken from bus routing header");

    // Bit 5 forced low by the special code
    property p_force0_bit5;
        @(posedge pclk) disable iff (!presetn)
        (cell_valid && offset_bit5_source == `SEL_FORCE0) |=> !ptr[`PTR_BIT5];
    endproperty
    a_force0_bit5: assert property (p_force0_bit5)
        else $error("forced offset bit 5 not zero");

    // Bit 5 from standard header below 32
    property p_bit5_std;
        @(posedge pclk) disable iff (!presetn)
        (cell_valid && offset_bit5_source <= `SEL_STD_LAST)
        |=> ptr[`PTR_BIT5] == $past(std_hdr[offset_bit5_source[4:0]]);
    endproperty
    a_bit5_std: assert property (p_bit5_std)
        else $error("offset bit 5 not taken from standard header");

    // Every cell gives a pointer strobe one cycle later
    property p_ptr_strobe;
        @(posedge pclk) disable iff (!presetn)
        cell_valid |=> ptr_valid;
    endproperty
    a_ptr_strobe: assert property (p_ptr_strobe)
        else $error("cell without a pointer strobe");

    // Refused writes must not disturb the documented fields
    property p_keep_unmapped;
        @(posedge pclk) disable iff (!presetn)
        (access && pwrite && !mapped)
        |=> $stable(offset_bit4_source) && $stable(offset_bit5_source);
    endproperty
    a_keep_unmapped: assert property (p_keep_unmapped)
        else $error("refused write changed a selector");

    // Every pair word reads zero above its two fields
    property p_pair_upper;
        @(posedge pclk) disable iff (!presetn)
        (setup && !pwrite && (|hit)) ##1 access |-> prdata[31:12] == 20'h0;
    endproperty
    a_pair_upper: assert property (p_pair_upper)
        else $error("reserved bits of a selector word not zero");

    // Main scenarios
    c_force0: cover property (@(posedge pclk) disable iff (!presetn)
        cell_valid && offset_bit4_source == `SEL_FORCE0);
    c_tandem: cover property (@(posedge pclk) disable iff (!presetn)
        cell_valid && offset_bit5_source == `SEL_TDM_LAST);
    c_write: cover property (@(posedge pclk) disable iff (!presetn)
        access && pwrite && aligned && idx == `IDX_BITS45);
    c_back2back: cover property (@(posedge pclk) disable iff (!presetn)
        cell_valid ##1 cell_valid);
    c_bus_msb: cover property (@(posedge pclk) disable iff (!presetn)
        cell_valid && offset_msb_source > `SEL_BUS_FIRST);

endmodule

//--- core/dsp_params.svh
`ifndef DSP_PARAMS_SVH
`define DSP_PARAMS_SVH

// Field geometry
`define SEL_W 6
`define PTR_W 13
`define SEL_STD_LAST 6'h1F
`define SEL_TDM_FIRST 6'h20
`define SEL_TDM_LAST 6'h2F
`define SEL_BUS_FIRST 6'h30
`define SEL_FORCE0 6'h30
`define SEL_RST 6'h30
`define FIELD1_LO 6
// Offset positions of the two documented fields
`define PTR_BIT4 4
`define PTR_BIT5 5

// Header widths
`define STD_W 32
`define TDM_W 16
`define BUS_W 16

// Register indices; byte address is four times the index
`define IDX_BITS45 10'h20E
`define IDX_PAIR0 10'h212
`define IDX_STEP 2
`define IDX_STATUS 10'h220
`define NUM_PAIRS 7

// Bus widths
`define ADDR_W 12
`define DATA_W 32

`endif

//--- core/dsp_pkg.sv
package dsp_pkg;
    // One selector field
    typedef logic [5:0] sel_t;
    // Assembled state memory offset
    typedef logic [12:0] ptr_t;
    // One bus word
    typedef logic [31:0] word_t;
endpackage

//--- bench/testbench.sv
`timescale 1ns/10ps
module testbench;
    import dsp_pkg::*;
    // Bench clock, reset and APB master side
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    word_t pwdata = 32'h0000_0000;
    word_t prdata;
    logic pready;
    logic pslverr;
    // Cell path stimulus and result
    logic cell_valid = 1'b0;
    logic [31:0] std_hdr = 32'h0000_0000;
    logic [15:0] tandem_hdr = 16'h0000;
    logic [15:0] bus_hdr = 16'h0000;
    ptr_t ptr;
    logic ptr_valid;
    // Fixed seed keeps every run repeatable
    integer seed = 32'hF4535E9E;
    int num_errors = 0;
    int total_checks = 0;
    // Selector shadow and pending expectations
    sel_t sel_m [13];
    ptr_t exp_ptr [$];
    // Last expected pointer, for the status word
    ptr_t last_ptr = 13'h0000;
    logic [32:0] exp_rd [$];

    // Free-running 100 MHz clock
    always #5 pclk = ~pclk;

    discard_state_pointer_select DUT (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .cell_valid(cell_valid), .std_hdr(std_hdr), .tandem_hdr(tandem_hdr),
        .bus_hdr(bus_hdr), .ptr(ptr), .ptr_valid(ptr_valid)
    );

    // Source bit for one selector value
    function automatic logic pick(sel_t v, logic [31:0] s, logic [15:0] t, logic [15:0] b);
        if (v < 6'h20) return s[v[4:0]];
        if (v < 6'h30) return t[v[3:0]];
        if (v == 6'h30) return 1'b0;
        return b[v[3:0]];
    endfunction

    // Verdict and end of run
    task stop_test;
        // Leftover notes mean a result never showed up
        if (exp_ptr.size() != 0 || exp_rd.size() != 0) num_errors++;
        if (num_errors == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask

    // One compare, counted
    task chk(input logic [32:0] e, input logic [32:0] g);
        total_checks++;
        if (e !== g) begin
            num_errors++;
            $display("[ERR] %0t exp %h got %h", $time, e, g);
        end
    endtask

    // One APB transfer; waits on pready, never on a cycle count
    task apb(input logic wr, input logic [11:0] a, input word_t d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Read with expected {pslverr, prdata} noted first
    task rd(input logic [11:0] a, input logic [32:0] e);
        exp_rd.push_back(e);
        apb(1'b0, a, 32'h0000_0000);
    endtask

    // Write with expected {pslverr, prdata} noted first; writes show zero data
    task wr(input logic [11:0] a, input word_t d, input logic err);
        exp_rd.push_back({err, 32'h0000_0000});
        apb(1'b1, a, d);
    endtask

    // Program selector pair k, junk in the unused upper bits, then read back
    task setp(input int k, input sel_t lo, input sel_t hi, input word_t junk);
        logic [11:0] a;
        a = 12'((32'h212 - 2 * k) * 4);
        wr(a, {junk[31:12], hi, lo}, 1'b0);
        sel_m[2 * k] = lo;
        if (k < 6) sel_m[2 * k + 1] = hi;
        rd(a, {21'h0, (k < 6) ? hi : 6'h00, lo});
    endtask

    // Back-to-back cells with random headers
    task cells(input int n);
        logic [31:0] s;
        logic [15:0] t;
        logic [15:0] b;
        ptr_t e;
        for (int i = 0; i < n; i++) begin
            @(posedge pclk);
            s = $random(seed);
            t = 16'($random(seed));
            b = 16'($random(seed));
            cell_valid <= 1'b1;
            std_hdr <= s;
            tandem_hdr <= t;
            bus_hdr <= b;
            for (int j = 0; j < 13; j++) e[j] = pick(sel_m[j], s, t, b);
            exp_ptr.push_back(e);
            last_ptr = e;
        end
        @(posedge pclk);
        cell_valid <= 1'b0;
    endtask

    // Watcher: takes the oldest note whenever a result appears
    always @(posedge pclk) begin
        if (psel && penable && pready === 1'b1 && exp_rd.size() != 0)
            chk(exp_rd.pop_front(), {pslverr, prdata});
        // A pulse with no cell behind it also fails
        if (ptr_valid === 1'b1)
            chk((exp_ptr.size() != 0) ?
                {20'h0, exp_ptr.pop_front()} : 33'h1FFFFFFFF, {20'h0, ptr});
    end

    // Main sequence
    initial begin
        for (int j = 0; j < 13; j++) sel_m[j] = 6'h30;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        rd(12'h838, {21'h0, 12'hC30});
        cells(2);
        // Unmapped aligned place refuses both a read and a write
        rd(12'h004, 33'h100000000);
        wr(12'h004, 32'hFFFF_FFFF, 1'b1);
        for (int k = 0; k < 7; k++)
            setp(k, sel_t'($random(seed)), sel_t'($random(seed)), $random(seed));
        cells(20);
        // Status word shows the last pointer and ignores writes
        rd(12'h880, {20'h0, last_ptr});
        wr(12'h880, 32'hFFFF_FFFF, 1'b0);
        rd(12'h880, {20'h0, last_ptr});
        // Every code through both fields of the documented word
        for (int v = 0; v < 64; v++) begin
            setp(2, sel_t'(v), sel_t'(63 - v), $random(seed));
            cells(1);
        end
        rd(12'h839, 33'h100000000);
        // Mid-run reset returns every selector to the force code
        repeat (2) @(posedge pclk);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        for (int j = 0; j < 13; j++) sel_m[j] = 6'h30;
        rd(12'h838, {21'h0, 12'hC30});
        rd(12'h818, {21'h0, 12'h030});
        rd(12'h880, 33'h000000000);
        cells(1);
        repeat (4) @(posedge pclk);
        stop_test;
    end

    // Watchdog well beyond the expected run length
    initial begin
        #100000;
        num_errors++;
        stop_test;
    end
endmodule
